// [two_wire_eeprom_slave.sv]
// Purpose: Slave protocol logic of a two-wire serial memory with timed writes.
// Assumes: Bus lines are asynchronous and oversampled by I_SYS_CLK.
// Notes: Page data is staged and committed at the end of the write time after the stop.
`default_nettype none
module two_wire_eeprom_slave #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_chip_select_strap_2,
  input wire logic i_chip_select_strap_1,
  input wire logic i_chip_select_strap_0,
  input wire logic i_write_protect,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_busy
);
  // ------------------------------------------------------------
  // Reset and input synchronisers
  // ------------------------------------------------------------
  logic rst_a, rst_b;
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_b <= rst_a;
    end
  end
  wire rst_n = rst_b;

  eeprom_pkg::bus_t s1, s2, s3;
  logic [2:0] strap1, strap2;
  logic wp1, wp2;
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      strap1 <= 3'h0;
      strap2 <= 3'h0;
      wp1 <= 1'b0;
      wp2 <= 1'b0;
    end else begin
      s1 <= '{scl: i_scl, sda: i_sda};
      s2 <= s1;
      s3 <= s2;
      strap1 <= {i_chip_select_strap_2, i_chip_select_strap_1, i_chip_select_strap_0};
      strap2 <= strap1;
      wp1 <= i_write_protect;
      wp2 <= wp1;
    end
  end

  wire scl_rise = s2.scl & ~s3.scl;
  wire scl_fall = ~s2.scl & s3.scl;
  wire start_det = s2.scl & s3.scl & ~s2.sda & s3.sda;
  wire stop_det = s2.scl & s3.scl & s2.sda & ~s3.sda;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [eeprom_pkg::ADDR_W-1:0] page_inc(
      input logic [eeprom_pkg::ADDR_W-1:0] a);
    logic [eeprom_pkg::PAGE_W-1:0] low;
    low = a[eeprom_pkg::PAGE_W-1:0] + 5'h01;
    page_inc = {a[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], low};
  endfunction : page_inc

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] mem [0:eeprom_pkg::MEM_DEPTH-1];
  logic [7:0] page_buf [0:31];
  logic [31:0] page_valid;

  // ------------------------------------------------------------
  // Protocol state
  // ------------------------------------------------------------
  eeprom_pkg::state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [eeprom_pkg::ADDR_W-1:0] addr, next_addr;
  logic [eeprom_pkg::ADDR_W-1:0] wbase, next_wbase;
  logic wr_pend, next_wr_pend;
  logic [31:0] wcnt, next_wcnt;
  logic busy, next_busy;
  logic sda_out, next_sda_out;
  logic sda_oe, next_sda_oe;
  logic buf_we, commit;
  logic [7:0] rdata;

  wire [7:0] sampled = {shreg[6:0], s2.sda};
  wire dev_match = (shreg[7:eeprom_pkg::DEV_CODE_LSB] == eeprom_pkg::DEV_CODE) &&
                   (shreg[3:eeprom_pkg::STRAP_LSB] == strap2);
  assign rdata = mem[addr];

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_addr = addr;
    next_wbase = wbase;
    next_wr_pend = wr_pend;
    next_wcnt = wcnt;
    next_busy = busy;
    next_sda_out = sda_out;
    next_sda_oe = sda_oe;
    buf_we = 1'b0;
    commit = 1'b0;
    if (busy) begin
      // The bus is ignored entirely while the timed write runs.
      next_sda_oe = 1'b0;
      if (wcnt == 32'h1) begin
        next_busy = 1'b0;
        commit = 1'b1;
        next_state = eeprom_pkg::ST_IDLE;
      end
      next_wcnt = wcnt - 32'h1;
    end else if (start_det) begin
      next_state = eeprom_pkg::ST_DEV;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
      next_wr_pend = 1'b0;
    end else if (stop_det) begin
      next_sda_oe = 1'b0;
      next_state = eeprom_pkg::ST_IDLE;
      if (wr_pend && !wp2) begin
        next_busy = 1'b1;
        next_wcnt = 32'(WRITE_CYCLES);
      end
      next_wr_pend = 1'b0;
    end else begin
      unique case (state)
        eeprom_pkg::ST_IDLE, eeprom_pkg::ST_IGNORE: ;
        eeprom_pkg::ST_DEV, eeprom_pkg::ST_AHI, eeprom_pkg::ST_ALO,
        eeprom_pkg::ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = sampled;
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b1;
            next_sda_out = 1'b0;
            next_state = eeprom_pkg::state_t'(state + 1);
            if (state == eeprom_pkg::ST_DEV) begin
              if (!dev_match) begin
                next_sda_oe = 1'b0;
                next_state = eeprom_pkg::ST_IGNORE;
              end
            end else if (state == eeprom_pkg::ST_AHI) begin
              next_addr[12:8] = shreg[4:0];
            end else if (state == eeprom_pkg::ST_ALO) begin
              next_addr[7:0] = shreg;
              next_wbase = {next_addr[12:8], shreg};
            end else begin
              buf_we = 1'b1;
              next_wr_pend = 1'b1;
              next_addr = page_inc(addr);
            end
          end
        end
        eeprom_pkg::ST_DEV_ACK, eeprom_pkg::ST_AHI_ACK, eeprom_pkg::ST_ALO_ACK,
        eeprom_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state = (state == eeprom_pkg::ST_WDATA_ACK) ? eeprom_pkg::ST_WDATA :
                         eeprom_pkg::state_t'(state + 1);
            if (state == eeprom_pkg::ST_DEV_ACK) begin
              next_state = eeprom_pkg::ST_AHI;
              if (shreg[0]) begin
                next_state = eeprom_pkg::ST_RDATA;
                next_sda_oe = ~rdata[7];
                next_sda_out = 1'b0;
                next_shreg = {rdata[6:0], 1'b1};
                next_bitcnt = 4'h1;
              end
            end
          end
        end
        eeprom_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_sda_oe = 1'b0;
              next_bitcnt = 4'h0;
              next_state = eeprom_pkg::ST_RACK;
              next_addr = addr + 13'h0001;
            end else begin
              next_sda_oe = ~shreg[7];
              next_shreg = {shreg[6:0], 1'b1};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        eeprom_pkg::ST_RACK: begin
          if (scl_rise) begin
            next_state = s2.sda ? eeprom_pkg::ST_IGNORE : eeprom_pkg::ST_RACK;
            next_bitcnt = s2.sda ? 4'h0 : 4'h1;
          end else if (scl_fall && bitcnt == 4'h1) begin
            next_state = eeprom_pkg::ST_RDATA;
            next_sda_oe = ~rdata[7];
            next_sda_out = 1'b0;
            next_shreg = {rdata[6:0], 1'b1};
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= eeprom_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      addr <= eeprom_pkg::ADDR_RESET;
      wbase <= eeprom_pkg::ADDR_RESET;
      wr_pend <= 1'b0;
      wcnt <= 32'h0;
      busy <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      addr <= next_addr;
      wbase <= next_wbase;
      wr_pend <= next_wr_pend;
      wcnt <= next_wcnt;
      busy <= next_busy;
      sda_out <= next_sda_out;
      sda_oe <= next_sda_oe;
    end
  end

  // ------------------------------------------------------------
  // Page staging and commit
  // ------------------------------------------------------------
  // Staging lets a later wrap overwrite earlier bytes before the commit.
  always_ff @(posedge I_SYS_CLK) begin
    if (buf_we) begin
      page_buf[addr[eeprom_pkg::PAGE_W-1:0]] <= shreg;
    end
    if (commit) begin
      for (int i = 0; i < 32; i++) begin
        if (page_valid[i]) begin
          mem[{wbase[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], 5'(i)}] <= page_buf[i];
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      page_valid <= 32'h0;
    end else if (commit || start_det && !busy) begin
      page_valid <= 32'h0;
    end else if (buf_we) begin
      page_valid[addr[eeprom_pkg::PAGE_W-1:0]] <= 1'b1;
    end
  end

  assign o_sda = sda_out;
  assign o_sda_oe = sda_oe;
  assign o_busy = busy;
endmodule : two_wire_eeprom_slave
`default_nettype wire

// [eeprom_pkg.sv]
// Purpose: Constants and types for the two-wire serial memory slave.
// Assumes: System clock of 200 MHz samples the bus lines.
// Notes: Function
// Function
// - Data changes only while clock low.
// - Falling data, clock high: start.
// - Rising data, clock high: stop, idle.
// - Bytes of eight, acknowledge on ninth.
// - Idle after power-up and after stop.
// - Address word top nibble is 1010.
// - Next three bits match strap inputs.
// - Address word low bit selects direction.
// - Match acknowledges; mismatch goes silent.
// - Write-protect high blocks array writes.
// - Byte write: two address bytes, data.
// - Stop after write starts timed cycle.
// - Page write takes up to 32 bytes.
// - Writes increment low five bits only.
// - Polling acknowledged only after write cycle.
// - Address counter keeps last plus one.
// - Reads wrap whole array, writes page.
// - Current read sends byte at counter.
// - Master acknowledge continues sequential read.
// - 32-byte pages, 13-bit word address.
`default_nettype none
package eeprom_pkg;
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int PAGE_W = 5;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam int DEV_CODE_LSB = 4;
  localparam int STRAP_LSB = 1;
  localparam int CLK_PERIOD_NS = 5;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES = (WRITE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

  typedef enum {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_AHI, ST_AHI_ACK, ST_ALO, ST_ALO_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_t;
endpackage : eeprom_pkg
`default_nettype wire

// [eeprom_monitor.sv]
// Purpose: Port checker for the two-wire memory slave.
// Assumes: The master changes data only while the clock is low.
// Notes: Bound to every slave instance.
`default_nettype none
module eeprom_monitor #(
  parameter int WRITE_CYCLES = 400
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  // --------
  // Checks
  // --------
  int cnt;
  int next_cnt;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  always_comb next_cnt = o_busy ? cnt + 1 : 0;
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) cnt <= 0;
    else cnt <= next_cnt;
  end
  sda_low_a: assert property (o_sda_oe |-> !o_sda)
    else $error("data line driven high");
  oe_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("drive began with clock high");
  oe_fall_a: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("release with clock high");
  oe_hold_a: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("drive changed in clock high");
  ack_width_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("drive too short");
  busy_quiet_a: assert property (o_busy |-> !o_sda_oe)
    else $error("answer while busy");
  busy_stop_a: assert property ($rose(o_busy) |-> i_scl && i_sda)
    else $error("write time began without stop");
  busy_len_a: assert property ($fell(o_busy) |-> cnt == WRITE_CYCLES)
    else $error("write time length wrong");
  cover property ($rose(o_busy));
  cover property ($fell(o_busy));
  cover property (o_sda_oe && i_scl);
endmodule : eeprom_monitor
bind two_wire_eeprom_slave eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_busy(o_busy));
`default_nettype wire

// [bus_master.sv]
// Purpose: Behavioural two-wire bus master.
// Assumes: The data line has a pull-up outside this model.
// Notes: One bit cell is 25 clocks; the clock line stands high between frames.
`default_nettype none
module bus_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Bus cycles
  // --------
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask : w
  task automatic start;
    o_sda <= 1'b1;
    w(6);
    o_scl <= 1'b1;
    w(6);
    o_sda <= 1'b0;
    w(6);
    o_scl <= 1'b0;
    w(6);
  endtask : start
  task automatic stop;
    o_sda <= 1'b0;
    w(6);
    o_scl <= 1'b1;
    w(6);
    o_sda <= 1'b1;
    w(12);
  endtask : stop
  // Data moves only in the low phase, so no bit is mistaken for a start or stop.
  task automatic bitx(input logic b, output logic r);
    o_sda <= b;
    w(6);
    o_scl <= 1'b1;
    w(6);
    r = i_sda;
    w(7);
    o_scl <= 1'b0;
    w(6);
  endtask : bitx
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(~ack, r);
  endtask : rbyte
endmodule : bus_master
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the two-wire memory slave.
// Assumes: Memory content is unknown until written.
// Notes: The write time is shortened to WC clocks.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 400;
  typedef struct packed {logic [2:0] strap; logic [7:0] dev; logic ack;} row_t;
  row_t rows [9] = '{'{3'h5, 8'ha8, 1'b0}, '{3'h5, 8'hae, 1'b0}, '{3'h5, 8'ha2, 1'b0},
    '{3'h5, 8'hba, 1'b0}, '{3'h5, 8'h2a, 1'b0}, '{3'h2, 8'ha4, 1'b1},
    '{3'h7, 8'hae, 1'b1}, '{3'h0, 8'ha0, 1'b1}, '{3'h5, 8'haa, 1'b1}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, msda, osda, oe, busy, a;
  wire logic sda;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  assign sda = msda & ~oe;
  two_wire_eeprom_slave #(.WRITE_CYCLES(WC)) u_dut (.I_SYS_CLK(clk), .I_RSTN(rstn),
    .i_scl(scl), .i_sda(sda), .i_chip_select_strap_2(strap[2]),
    .i_chip_select_strap_1(strap[1]), .i_chip_select_strap_0(strap[0]),
    .i_write_protect(wp), .o_sda(osda), .o_sda_oe(oe), .o_busy(busy));
  bus_master u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
  // --------
  // Tasks
  // --------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wadr(input logic [12:0] ad);
    u_mst.start();
    u_mst.wbyte(8'haa, a);
    chk(a, 1'b1);
    u_mst.wbyte({3'h0, ad[12:8]}, a);
    chk(a, 1'b1);
    u_mst.wbyte(ad[7:0], a);
    chk(a, 1'b1);
  endtask : wadr
  task automatic rsel;
    u_mst.start();
    u_mst.wbyte(8'hab, a);
    chk(a, 1'b1);
  endtask : rsel
  task automatic rdat(input logic ack, input logic [7:0] e);
    logic [7:0] d;
    u_mst.rbyte(ack, d);
    chk(d, e);
  endtask : rdat
  task automatic idle;
    for (int i = 0; i < WC + 20 && busy !== 1'b0; i++) @(posedge clk);
    #1 chk(busy, 1'b0);
    chk(osda, 1'b0);
  endtask : idle
  // The ceiling allows the whole sequence about three times over.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  // --------
  // Sequence
  // --------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      strap <= rows[i].strap;
      u_mst.start();
      u_mst.wbyte(rows[i].dev, a);
      u_mst.stop();
      chk(a, rows[i].ack);
    end
    #1 chk(busy, 1'b0);
    $display("address table done");
    wadr(13'h01fd);
    for (int i = 0; i < 4; i++) begin
      u_mst.wbyte(8'h30 + i[7:0], a);
      chk(a, 1'b1);
    end
    u_mst.stop();
    #1 chk(busy, 1'b1);
    u_mst.start();
    u_mst.wbyte(8'haa, a);
    u_mst.stop();
    chk(a, 1'b0);
    idle();
    $display("page write done");
    wadr(13'h01fd);
    rsel();
    rdat(1'b0, 8'h30);
    u_mst.stop();
    rsel();
    rdat(1'b1, 8'h31);
    rdat(1'b0, 8'h32);
    u_mst.stop();
    wadr(13'h01e0);
    rsel();
    rdat(1'b0, 8'h33);
    u_mst.stop();
    $display("reads done");
    wp <= 1'b1;
    wadr(13'h01fd);
    u_mst.wbyte(8'h5a, a);
    u_mst.stop();
    idle();
    wp <= 1'b0;
    wadr(13'h01fd);
    rsel();
    rdat(1'b0, 8'h30);
    u_mst.stop();
    $display("protect done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
